/* risc16_execute_assertions.sv */
// Port checks on the execute core
`timescale 1ns/10ps
`default_nettype none
module risc16_execute_assertions
  import risc16_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire mem_req_s    mem_req_o,
  input wire mem_rsp_s    mem_rsp_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !$past(wb_cyc_i && wb_stb_i)
    |=> wb_ack_o) else $error("ack not one cycle after request");
  a_write_data_zero: assert property (wb_ack_o && wb_we_i |-> wb_dat_o == 32'h0)
    else $error("read data not zero on write");
  a_unmapped_zero: assert property (wb_ack_o && wb_adr_i > ADDR_ACC |-> wb_dat_o == 32'h0)
    else $error("unmapped read not zero");
  a_mem_hold: assert property (mem_req_o.req && !mem_rsp_i.ack
    |=> mem_req_o.req && $stable(mem_req_o)) else $error("memory request moved");
  a_mem_release: assert property (mem_req_o.req && mem_rsp_i.ack |=> !mem_req_o.req)
    else $error("memory request not released");
  a_word_align: assert property (mem_req_o.req |-> mem_req_o.addr[1:0] == 2'b00)
    else $error("memory address not word aligned");
  a_reset_quiet: assert property (disable iff (1'b0) rst_i
    |=> !mem_req_o.req && !wb_ack_o && wb_dat_o == 32'h0) else $error("busy in reset");
endmodule // risc16_execute_assertions
`default_nettype wire

/* risc16_instruction_execute.sv */
// Decode and execute core for 16-bit instructions with a Wishbone control port
//
// The Wishbone interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none

module risc16_instruction_execute
  import risc16_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  output var  mem_req_s    mem_req_o,
  input  wire mem_rsp_s    mem_rsp_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o
);

  typedef struct packed {
    phase_e          phase;
    logic [31:0]     pc;
    logic [15:0]     ir;
    logic [31:0][31:0] gpr;
    logic [10:0]     kconst;
    logic            prefixed;
    logic            skip_pend;
    logic            slot_pend;
    logic [31:0]     slot_pc;
    status_s         status;
    status_s         saved;
    logic [31:0]     vector_base;
    logic [4:0]      floor;
    logic [4:0]      ceiling;
    logic            run;
    logic            load_en;
    logic [4:0]      load_idx;
    mem_req_s        mreq;
    logic            wb_ack;
    logic [31:0]     wb_data;
  } core_s;

  core_s       r_reg;
  core_s       r_next;
  logic [15:0] ir;
  logic [4:0]  a_idx;
  logic [4:0]  b_idx;
  logic [31:0] ra;
  logic [31:0] rb;
  logic [31:0] imm_ext;
  logic [31:0] operand;
  logic [31:0] second;
  logic [31:0] res;
  logic [32:0] wide;
  logic [31:0] seq_pc;
  logic [31:0] mem_addr;
  logic        take_trap;
  logic [5:0]  trap_num;
  logic [31:0] lim_word;

  function automatic logic cond_true(input logic [3:0] code, input status_s s);
    logic hit;
    hit = 1'b0;
    case (code)
      CC_C:    hit = s.c;
      CC_NC:   hit = ~s.c;
      CC_Z:    hit = s.z;
      CC_NZ:   hit = ~s.z;
      CC_MI:   hit = s.n;
      CC_PL:   hit = ~s.n;
      CC_GE:   hit = (s.n == s.v);
      CC_LT:   hit = (s.n != s.v);
      CC_LE:   hit = s.z | (s.n != s.v);
      CC_GT:   hit = ~s.z & (s.n == s.v);
      CC_V:    hit = s.v;
      CC_NV:   hit = ~s.v;
      CC_LS:   hit = s.c | s.z;
      CC_HI:   hit = ~s.c & ~s.z;
      default: hit = 1'b0;
    endcase
    return hit;
  endfunction

  // Byte lanes a Wishbone write is allowed to change
  function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                             input logic [3:0] sel);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction

  always_comb begin
    r_next    = r_reg;
    ir        = r_reg.ir;
    a_idx     = ir[4:0];
    b_idx     = ir[9:5];
    ra        = r_reg.gpr[a_idx];
    rb        = r_reg.gpr[b_idx];
    imm_ext   = {16'h0000, r_reg.kconst, ir[9:5]};
    operand   = r_reg.prefixed ? imm_ext : rb;
    second    = ir[10] ? imm_ext : rb;
    res       = ra;
    wide      = '0;
    mem_addr  = '0;
    take_trap = 1'b0;
    trap_num  = '0;
    lim_word  = '0;
    // A pending delay slot decides where control goes after this instruction
    seq_pc    = r_reg.slot_pend ? r_reg.slot_pc : r_reg.pc + PC_STEP;

    unique case (r_reg.phase)
      PH_FETCH: begin
        if (!r_reg.mreq.req) begin
          if (r_reg.run) begin
            r_next.mreq = '{req: 1'b1, we: 1'b0, addr: r_reg.pc & ALIGN_MASK, wdata: '0};
          end
        end else if (mem_rsp_i.ack) begin
          r_next.mreq.req = 1'b0;
          r_next.ir       = r_reg.pc[1] ? mem_rsp_i.rdata[31:16] : mem_rsp_i.rdata[15:0];
          r_next.phase    = PH_EXEC;
        end
      end

      PH_EXEC: begin
        r_next.phase     = PH_FETCH;
        r_next.pc        = seq_pc;
        r_next.slot_pend = 1'b0;
        r_next.skip_pend = 1'b0;
        r_next.kconst    = '0;
        r_next.prefixed  = 1'b0;
        if (r_reg.skip_pend) begin
          // Suppressed instruction: nothing but the advance
        end else if (ir[15:13] == OP3_FRAME_WRITE || ir[15:13] == OP3_FRAME_READ) begin
          mem_addr = (r_reg.gpr[STACK_REG] + {22'h0, ir[12:5], 2'b00}) & ALIGN_MASK;
          r_next.mreq     = '{req: 1'b1, we: ~ir[13], addr: mem_addr, wdata: ra};
          r_next.load_en  = ir[13];
          r_next.load_idx = a_idx;
          r_next.phase    = PH_DATA;
        end else if (ir[15:12] == OP4_PTR_WRITE || ir[15:12] == OP4_PTR_READ) begin
          mem_addr = (r_reg.gpr[PTR_BASE + {3'b000, ir[11:10]}]
                      + {{14{r_reg.kconst[10]}}, r_reg.kconst, ir[9:5], 2'b00})
                     & ALIGN_MASK;
          r_next.mreq     = '{req: 1'b1, we: ~ir[12], addr: mem_addr, wdata: ra};
          r_next.load_en  = ir[12];
          r_next.load_idx = a_idx;
          r_next.phase    = PH_DATA;
        end else if (ir[15:11] == OP5_PREFIX_LOAD) begin
          r_next.kconst   = ir[10:0];
          r_next.prefixed = 1'b1;
        end else if (ir[15:8] == OP8_WINDOW_PUSH) begin
          r_next.status.window = r_reg.status.window - WINDOW_STEP;
          r_next.gpr[STACK_REG] = r_reg.gpr[FRAME_REG] - {22'h0, ir[7:0], 2'b00};
          if (r_reg.status.window == r_reg.floor) begin
            take_trap = 1'b1;
            trap_num  = TRAP_PUSH;
          end
        end else if (ir[15:8] == OP8_SOFT_TRAP) begin
          take_trap = 1'b1;
          trap_num  = ir[5:0];
        end else if (ir[15:11] == OP5_WIDE_GROUP) begin
          case (ir[15:5])
            OP11_INVERT: r_next.gpr[a_idx] = ~ra;
            OP11_NEGATE: r_next.gpr[a_idx] = '0 - ra;
            OP11_WINDOW_POP: begin
              r_next.status.window = r_reg.status.window + WINDOW_STEP;
              if (r_reg.status.window == r_reg.ceiling) begin
                take_trap = 1'b1;
                trap_num  = TRAP_POP;
              end
            end
            OP11_EXC_RETURN: begin
              // Return is immediate: no delay slot
              r_next.pc     = {ra[30:0], 1'b0};
              r_next.status = r_reg.saved;
            end
            OP11_MUL_STEP: begin
              res = {r_reg.gpr[ACC_REG][30:0], 1'b0};
              r_next.gpr[ACC_REG] = r_reg.gpr[ACC_REG][31] ? res + ra : res;
            end
            OP11_SKIP_ZERO:  r_next.skip_pend = (ra == '0);
            OP11_SKIP_NZERO: r_next.skip_pend = (ra != '0);
            OP11_SKIP_COND:  r_next.skip_pend = cond_true(ir[3:0], r_reg.status);
            OP11_CTL_WRITE: begin
              // Status is live next cycle; software pads with a no-op
              if (r_reg.kconst == CTL_STATUS) begin
                r_next.status = ra[15:0];
              end
            end
            OP11_CTL_READ: begin
              if (r_reg.kconst == CTL_STATUS) begin
                r_next.gpr[a_idx] = {16'h0000, r_reg.status};
              end
            end
            OP11_IND_JUMP, OP11_IND_CALL: begin
              if (!r_reg.slot_pend) begin
                r_next.slot_pend = 1'b1;
                r_next.slot_pc   = {ra[30:0], 1'b0};
                if (ir[5]) begin
                  r_next.gpr[LINK_REG] = (r_reg.pc + LINK_STEP) >> 1;
                end
              end
            end
            default: ;
          endcase
        end else begin
          case (ir[15:10])
            OP_ADD, OP_ADD + 6'h01: begin
              wide = {1'b0, ra} + {1'b0, second};
              res  = wide[31:0];
              r_next.gpr[a_idx] = res;
              r_next.status.c   = wide[32];
              r_next.status.v   = (ra[31] == second[31]) && (res[31] != ra[31]);
              r_next.status.n   = res[31];
              r_next.status.z   = (res == '0);
            end
            OP_SUB, OP_SUB + 6'h01, OP_COMPARE_ONLY, OP_COMPARE_ONLY + 6'h01: begin
              wide = {1'b0, ra} - {1'b0, second};
              res  = wide[31:0];
              if (ir[15:11] != OP_COMPARE_ONLY[5:1]) begin
                r_next.gpr[a_idx] = res;
              end
              // Carry holds the borrow of the subtraction
              r_next.status.c = wide[32];
              r_next.status.v = (ra[31] != second[31]) && (res[31] != ra[31]);
              r_next.status.n = res[31];
              r_next.status.z = (res == '0);
            end
            OP_SHIFT_LEFT, OP_SHIFT_LEFT + 6'h01: begin
              r_next.gpr[a_idx] = ra << (ir[10] ? ir[9:5] : rb[4:0]);
            end
            OP_SHIFT_RIGHT, OP_SHIFT_RIGHT + 6'h01: begin
              r_next.gpr[a_idx] = ra >> (ir[10] ? ir[9:5] : rb[4:0]);
            end
            OP_ARITH_SHIFT, OP_ARITH_SHIFT + 6'h01: begin
              r_next.gpr[a_idx] = $signed(ra) >>> (ir[10] ? ir[9:5] : rb[4:0]);
            end
            OP_COPY:           r_next.gpr[a_idx] = rb;
            OP_IMMEDIATE_MOVE: r_next.gpr[a_idx] = imm_ext;
            OP_UPPER_HALF:     r_next.gpr[a_idx] = {r_reg.kconst, ir[9:5], ra[15:0]};
            OP_CONJ, OP_CONJ_NOT, OP_DISJ, OP_PARITY: begin
              case (ir[11:10])
                2'b10:   res = ra & operand;
                2'b11:   res = ra & ~operand;
                2'b00:   res = ra | operand;
                default: res = ra ^ operand;
              endcase
              r_next.gpr[a_idx] = res;
              r_next.status.n   = res[31];
              r_next.status.z   = (res == '0);
            end
            OP_BIT_GEN:      r_next.gpr[a_idx] = 32'h0000_0001 << ir[9:5];
            OP_BYTE_EXTRACT: r_next.gpr[a_idx] = (ra >> {rb[1:0], 3'b000}) & BYTE_MASK;
            OP_SKIP_BIT_CLR: r_next.skip_pend = ~ra[ir[9:5]];
            OP_SKIP_BIT_SET: r_next.skip_pend = ra[ir[9:5]];
            OP_MEM_READ_WORD, OP_MEM_WRITE_WORD: begin
              mem_addr = (rb + {{19{r_reg.kconst[10]}}, r_reg.kconst, 2'b00})
                         & ALIGN_MASK;
              r_next.mreq     = '{req: 1'b1, we: ir[10], addr: mem_addr, wdata: ra};
              r_next.load_en  = ~ir[10];
              r_next.load_idx = a_idx;
              r_next.phase    = PH_DATA;
            end
            OP_REL_JUMP, OP_REL_SUB_JUMP: begin
              if (!r_reg.slot_pend) begin
                r_next.slot_pend = 1'b1;
                r_next.slot_pc   = r_reg.pc + PC_STEP
                                   + {{20{ir[10]}}, ir[10:0], 1'b0};
                if (ir[11]) begin
                  r_next.gpr[LINK_REG] = (r_reg.pc + LINK_STEP) >> 1;
                end
              end
            end
            default: ;
          endcase
        end

        if (take_trap) begin
          r_next.saved          = r_next.status;
          r_next.status.int_en  = 1'b0;
          r_next.status.window  = r_next.status.window - WINDOW_STEP;
          r_next.status.prio    = trap_num;
          r_next.gpr[LINK_REG]  = (r_reg.pc + PC_STEP) >> 1;
          r_next.slot_pend      = 1'b0;
          r_next.mreq = '{req: 1'b1, we: 1'b0,
                          addr: r_reg.vector_base + {24'h0, trap_num, 2'b00}, wdata: '0};
          r_next.phase = PH_VECTOR;
        end
      end

      PH_DATA: begin
        if (mem_rsp_i.ack) begin
          r_next.mreq.req = 1'b0;
          if (r_reg.load_en) begin
            r_next.gpr[r_reg.load_idx] = mem_rsp_i.rdata;
          end
          r_next.phase = PH_FETCH;
        end
      end

      PH_VECTOR: begin
        if (mem_rsp_i.ack) begin
          r_next.mreq.req = 1'b0;
          r_next.pc       = {mem_rsp_i.rdata[30:0], 1'b0};
          r_next.phase    = PH_FETCH;
        end
      end
    endcase

    // Wishbone slave: one wait state, ack for one cycle, unmapped reads give zero
    r_next.wb_ack = wb_cyc_i & wb_stb_i & ~r_reg.wb_ack;
    if (r_next.wb_ack) begin
      r_next.wb_data = '0;
      if (wb_we_i) begin
        case (wb_adr_i)
          ADDR_CTRL: begin
            r_next.run = lane_merge({31'h0, r_reg.run}, wb_dat_i, wb_sel_i) != '0;
          end
          ADDR_VECTOR_TABLE_BASE: r_next.vector_base = lane_merge(r_reg.vector_base, wb_dat_i, wb_sel_i);
          ADDR_WINLIM: begin
            // Only the two five-bit limit fields exist; upper bits are dropped
            lim_word = lane_merge({22'h0, r_reg.ceiling, r_reg.floor}, wb_dat_i, wb_sel_i);
            {r_next.ceiling, r_next.floor} = lim_word[9:0];
          end
          default: ;
        endcase
      end else begin
        case (wb_adr_i)
          ADDR_CTRL:    r_next.wb_data = {31'h0, r_reg.run};
          ADDR_STATUS:  r_next.wb_data = {16'h0000, r_reg.status};
          ADDR_PC:      r_next.wb_data = r_reg.pc;
          ADDR_VECTOR_TABLE_BASE: r_next.wb_data = r_reg.vector_base;
          ADDR_WINLIM:  r_next.wb_data = {22'h0, r_reg.ceiling, r_reg.floor};
          ADDR_ACC:     r_next.wb_data = r_reg.gpr[ACC_REG];
          default:      r_next.wb_data = '0;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      r_reg               <= '0;
      r_reg.phase         <= PH_FETCH;
      r_reg.pc            <= RESET_PC;
      r_reg.vector_base   <= VECTOR_TABLE_BASE_RST;
      r_reg.status.window <= WINDOW_RST;
      r_reg.floor         <= FLOOR_RST;
      r_reg.ceiling       <= CEILING_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign mem_req_o = r_reg.mreq;
  assign wb_dat_o  = r_reg.wb_data;
  assign wb_ack_o  = r_reg.wb_ack;

endmodule // risc16_instruction_execute

`default_nettype wire

/* risc16_instruction_execute_test.sv */
// Runs a short program on the core and checks its stores and registers
`timescale 1ns/10ps
`default_nettype none
module risc16_instruction_execute_test;
  import risc16_pkg::*;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, wb_ack_o;
  logic [7:0]  adr = '0;
  logic [3:0]  sel = '0;
  logic [31:0] dat = '0, rd, wb_dat_o, r;
  mem_req_s    mem_req;
  mem_rsp_s    mem_rsp;
  int          n_fail = 0, n_checks = 0;
  logic [15:0] prog [0:31];
  logic [31:0] ev [$];
  risc16_instruction_execute dut_u (.clk_i(clk_i), .rst_i(rst_i), .mem_req_o(mem_req),
    .mem_rsp_i(mem_rsp), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
  risc16_memory_model mem_u (.clk_i(clk_i), .rst_i(rst_i), .req_i(mem_req), .rsp_o(mem_rsp));
  initial forever #12.5 clk_i = ~clk_i;
  function automatic logic [15:0] pf(input logic [10:0] k);
    return {OP5_PREFIX_LOAD, k};
  endfunction
  function automatic logic [15:0] mv(input logic [4:0] i, input logic [4:0] a);
    return {OP_IMMEDIATE_MOVE, i, a};
  endfunction
  function automatic logic [15:0] sts(input logic [4:0] a, input logic [7:0] i);
    return {OP3_FRAME_WRITE, i, a};
  endfunction
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we  <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1) @(posedge clk_i);
    rd = wb_dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    prog = '{pf(11'h010), mv(5'h00, 5'd14), mv(5'h05, 5'd1), pf(11'h7FF), mv(5'h1F, 5'd2),
      {OP_ADD, 5'd1, 5'd2}, sts(5'd2, 8'h00), {OP_SUB, 5'd1, 5'd1}, {OP11_SKIP_COND, 5'h02},
      mv(5'h07, 5'd1), sts(5'd1, 8'h01), pf(11'h400), {OP_UPPER_HALF, 5'h00, 5'd2},
      {6'h0B, 5'd1, 5'd2}, sts(5'd2, 8'h02), mv(5'h03, 5'd5), {OP_BYTE_EXTRACT, 5'd5, 5'd2},
      sts(5'd2, 8'h03), 16'h7500, {OP_REL_JUMP[5:1], 11'h002}, mv(5'h03, 5'd6),
      mv(5'h09, 5'd6), sts(5'd6, 8'h04), pf(11'h400), {OP_UPPER_HALF, 5'h00, 5'd0},
      {OP11_MUL_STEP, 5'd5}, sts(5'd0, 8'h05), {OP_SKIP_BIT_SET, 5'd1, 5'd5},
      mv(5'h00, 5'd5), sts(5'd5, 8'h06), {OP_REL_JUMP[5:1], 11'h7FF}, 16'h3000};
    // Program holds no status control write, so no no-op padding is owed
    for (int i = 0; i < 16; i++) mem_u.mem[i] = {prog[2*i+1], prog[2*i]};
    r = 32'hFFFF + 5;
    ev.push_back(r);
    ev.push_back(5 - 5);
    r = $signed({16'h8000, r[15:0]}) >>> 1;
    ev.push_back(r);
    ev.push_back((r >> 24) & 32'hFF);
    ev.push_back(3);
    ev.push_back((32'h8000_0000 << 1) + 3);
    ev.push_back(3);
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, ADDR_VECTOR_TABLE_BASE, '0);
    check("vector base", rd, VECTOR_TABLE_BASE_RST);
    wb(1'b1, ADDR_VECTOR_TABLE_BASE, 32'h0000_0240);
    wb(1'b0, ADDR_VECTOR_TABLE_BASE, '0);
    check("vector base rw", rd, 32'h0000_0240);
    wb(1'b1, 8'h20, 32'hFFFF_FFFF);
    wb(1'b0, 8'h20, '0);
    check("unmapped", rd, 32'h0000_0000);
    $display("register test done");
    wb(1'b1, ADDR_CTRL, 32'h0000_0001);
    for (int i = 0; i < 4000 && mem_u.wr_q.size() < 7; i++) @(posedge clk_i);
    check("store count", mem_u.wr_q.size(), 7);
    for (int k = 0; k < 7 && k < mem_u.wr_q.size(); k++) begin
      check("store addr", mem_u.wr_q[k][63:32], 32'h200 + 4 * k);
      check("store data", mem_u.wr_q[k][31:0], ev[k]);
    end
    wb(1'b0, ADDR_ACC, '0);
    check("accumulator", rd, ev[5]);
    wb(1'b0, ADDR_STATUS, '0);
    check("window", {27'h0, rd[8:4]}, {27'h0, WINDOW_RST});
    $display("program test done");
    finish_test();
  end
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    finish_test();
  end
endmodule // risc16_instruction_execute_test
bind risc16_instruction_execute risc16_execute_assertions chk_u (.clk_i(clk_i), .rst_i(rst_i),
  .mem_req_o(mem_req_o), .mem_rsp_i(mem_rsp_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o));
`default_nettype wire

/* risc16_memory_model.sv */
// Memory that answers fetch and data requests after a random wait
`timescale 1ns/10ps
`default_nettype none
module risc16_memory_model
  import risc16_pkg::*;
(
  input  wire logic     clk_i,
  input  wire logic     rst_i,
  input  wire mem_req_s req_i,
  output var  mem_rsp_s rsp_o
);
  logic [31:0] mem [0:1023];
  logic [63:0] wr_q [$];
  int          seed = 23238;
  int          wait_n = 0;
  initial rsp_o = '0;
  always @(posedge clk_i) begin
    rsp_o.ack <= 1'b0;
    // Data lines flip to the complement of their last word each cycle between answers
    rsp_o.rdata <= ~rsp_o.rdata;
    if (!rst_i && req_i.req && !rsp_o.ack) begin
      if (wait_n == 0) begin
        rsp_o.ack <= 1'b1;
        if (req_i.we) begin
          mem[req_i.addr[11:2]] = req_i.wdata;
          wr_q.push_back({req_i.addr, req_i.wdata});
        end else
          rsp_o.rdata <= mem[req_i.addr[11:2]];
        wait_n = $unsigned($random(seed)) % 3;
      end else
        wait_n = wait_n - 1;
    end
  end
endmodule // risc16_memory_model
`default_nettype wire

/* risc16_pkg.sv */
// Shared types and constants for the 16-bit-instruction execute core
package risc16_pkg;

  // Primary opcodes of six bits
  localparam logic [5:0] OP_ADD           = 6'h00;
  localparam logic [5:0] OP_SUB           = 6'h02;
  localparam logic [5:0] OP_COMPARE_ONLY  = 6'h04;
  localparam logic [5:0] OP_SHIFT_LEFT    = 6'h06;
  localparam logic [5:0] OP_SHIFT_RIGHT   = 6'h08;
  localparam logic [5:0] OP_ARITH_SHIFT   = 6'h0A;
  localparam logic [5:0] OP_COPY          = 6'h0C;
  localparam logic [5:0] OP_IMMEDIATE_MOVE = 6'h0D;
  localparam logic [5:0] OP_CONJ          = 6'h0E;
  localparam logic [5:0] OP_CONJ_NOT      = 6'h0F;
  localparam logic [5:0] OP_DISJ          = 6'h10;
  localparam logic [5:0] OP_PARITY        = 6'h11;
  localparam logic [5:0] OP_BIT_GEN       = 6'h12;
  localparam logic [5:0] OP_BYTE_EXTRACT  = 6'h13;
  localparam logic [5:0] OP_SKIP_BIT_CLR  = 6'h14;
  localparam logic [5:0] OP_SKIP_BIT_SET  = 6'h15;
  localparam logic [5:0] OP_MEM_READ_WORD = 6'h16;
  localparam logic [5:0] OP_MEM_WRITE_WORD = 6'h17;
  localparam logic [5:0] OP_UPPER_HALF    = 6'h1B;
  localparam logic [5:0] OP_REL_JUMP      = 6'h20;
  localparam logic [5:0] OP_REL_SUB_JUMP  = 6'h22;
  // Shorter and longer opcodes
  localparam logic [2:0] OP3_FRAME_WRITE  = 3'h6;
  localparam logic [2:0] OP3_FRAME_READ   = 3'h7;
  localparam logic [3:0] OP4_PTR_WRITE    = 4'hA;
  localparam logic [3:0] OP4_PTR_READ     = 4'hB;
  localparam logic [4:0] OP5_PREFIX_LOAD  = 5'h13;
  localparam logic [4:0] OP5_WIDE_GROUP   = 5'h0F;
  localparam logic [7:0] OP8_WINDOW_PUSH  = 8'h78;
  localparam logic [7:0] OP8_SOFT_TRAP    = 8'h79;
  localparam logic [10:0] OP11_INVERT     = 11'h3E0;
  localparam logic [10:0] OP11_NEGATE     = 11'h3E1;
  localparam logic [10:0] OP11_WINDOW_POP = 11'h3ED;
  localparam logic [10:0] OP11_EXC_RETURN = 11'h3EE;
  localparam logic [10:0] OP11_MUL_STEP   = 11'h3F4;
  localparam logic [10:0] OP11_SKIP_ZERO  = 11'h3F6;
  localparam logic [10:0] OP11_SKIP_COND  = 11'h3F7;
  localparam logic [10:0] OP11_CTL_WRITE  = 11'h3F8;
  localparam logic [10:0] OP11_CTL_READ   = 11'h3F9;
  localparam logic [10:0] OP11_SKIP_NZERO = 11'h3FA;
  localparam logic [10:0] OP11_IND_JUMP   = 11'h3FE;
  localparam logic [10:0] OP11_IND_CALL   = 11'h3FF;

  // Fixed register roles
  localparam logic [4:0] ACC_REG   = 5'h00;
  localparam logic [4:0] PTR_BASE  = 5'h08;
  localparam logic [4:0] STACK_REG = 5'h0E;
  localparam logic [4:0] LINK_REG  = 5'h0F;
  localparam logic [4:0] FRAME_REG = 5'h1E;

  localparam logic [31:0] RESET_PC     = 32'h0000_0000;
  localparam logic [31:0] VECTOR_TABLE_BASE_RST  = 32'h0000_0100;
  localparam logic [4:0]  WINDOW_RST   = 5'h10;
  localparam logic [4:0]  FLOOR_RST    = 5'h01;
  localparam logic [4:0]  CEILING_RST  = 5'h1E;
  localparam logic [4:0]  WINDOW_STEP  = 5'h01;
  localparam logic [5:0]  TRAP_PUSH    = 6'h01;
  localparam logic [5:0]  TRAP_POP     = 6'h02;
  localparam logic [31:0] PC_STEP      = 32'h0000_0002;
  localparam logic [31:0] LINK_STEP    = 32'h0000_0004;
  localparam logic [31:0] ALIGN_MASK   = 32'hFFFF_FFFC;
  localparam logic [31:0] BYTE_MASK    = 32'h0000_00FF;
  localparam logic [10:0] CTL_STATUS   = 11'h000;

  // Wishbone register byte addresses
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_STATUS  = 8'h04;
  localparam logic [7:0] ADDR_PC      = 8'h08;
  localparam logic [7:0] ADDR_VECTOR_TABLE_BASE = 8'h0C;
  localparam logic [7:0] ADDR_WINLIM  = 8'h10;
  localparam logic [7:0] ADDR_ACC     = 8'h14;

  typedef enum logic [3:0] {
    CC_C = 4'h0, CC_NC = 4'h1, CC_Z = 4'h2, CC_NZ = 4'h3, CC_MI = 4'h4, CC_PL = 4'h5,
    CC_GE = 4'h6, CC_LT = 4'h7, CC_LE = 4'h8, CC_GT = 4'h9, CC_V = 4'hA, CC_NV = 4'hB,
    CC_LS = 4'hC, CC_HI = 4'hD
  } cond_e;

  typedef enum logic [1:0] {
    PH_FETCH = 2'b00, PH_EXEC = 2'b01, PH_DATA = 2'b10, PH_VECTOR = 2'b11
  } phase_e;

  typedef struct packed {
    logic [5:0] prio;
    logic       int_en;
    logic [4:0] window;
    logic       n;
    logic       v;
    logic       z;
    logic       c;
  } status_s;

  typedef struct packed {
    logic        req;
    logic        we;
    logic [31:0] addr;
    logic [31:0] wdata;
  } mem_req_s;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } mem_rsp_s;

endpackage
